// >>> hw/udi_irq_regs.sv
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - Enable writes of one set mask bits
// - Disable writes of one clear mask bits
// - Mask register reads enabled sources
// - Mask bit 12 fixed at one
// - Resume mask enabled after reset
// - Endpoint status follows any endpoint flag
// - Endpoint status cleared only at source
// - Three ms idle sets suspend, enters suspend
// - Resume signalling sets resume flag
// - Start-of-frame token sets frame flag
// - Bus reset end sets bit 12
// - Resume or reset sets wakeup flag
// - Clear register ones clear event flags
// - Mask reads 0x1200 after reset
module udi_irq_regs
	import udi_pkg::*;
#(
	parameter int unsigned IDLE_LIMIT = IDLE_CYCLES
) (
	input  wire logic                      clock,
	input  wire logic                      rst_b,
	input  wire udi_pkg::udi_bus_req_t     busReq,
	output logic [udi_pkg::DATA_W-1:0]     rdata,
	input  wire udi_pkg::udi_bus_evt_t     busEvt,
	input  wire logic [udi_pkg::NUM_EP-1:0] setupPacketReceived,
	input  wire logic [udi_pkg::NUM_EP-1:0] receiveBankAFull,
	input  wire logic [udi_pkg::NUM_EP-1:0] receiveBankBFull,
	input  wire logic [udi_pkg::NUM_EP-1:0] transmitAcknowledged,
	input  wire logic [udi_pkg::NUM_EP-1:0] stallAcknowledged,
	output logic                           suspended,
	output logic                           irq
);
	import udi_pkg::*;

	initial begin
		if (IDLE_LIMIT < 2) $error("udi_irq_regs: IDLE_LIMIT too small");
	end

	logic [DATA_W-1:0] mask_q, mask_d;
	logic [DATA_W-1:0] pend_q, pend_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic              irq_q, irq_d;
	logic              susp_q, susp_d;
	logic [NUM_EP-1:0] epAny;
	logic              idleExpired;
	logic              wrSet, wrClr, wrAck;

	assign wrSet = busReq.wr && busReq.addr == OFS_ENABLE_SET;
	assign wrClr = busReq.wr && busReq.addr == OFS_ENABLE_CLEAR;
	assign wrAck = busReq.wr && busReq.addr == OFS_PENDING_CLR;

	// Endpoint sources are levels from the endpoint registers on this clock
	assign epAny = setupPacketReceived | receiveBankAFull | receiveBankBFull
		| transmitAcknowledged | stallAcknowledged;

	udi_idle_timer #(
		.LIMIT(IDLE_LIMIT)
	) u_idle (
		.clock    (clock),
		.rst_b    (rst_b),
		.activity (busEvt.busActivity),
		.expired  (idleExpired)
	);

	// Mask register
	always_comb begin
		mask_d = mask_q;
		if (wrSet) begin
			mask_d = mask_d | (busReq.wdata & MASK_WRITABLE);
		end
		if (wrClr) begin
			mask_d = mask_d & ~(busReq.wdata & MASK_WRITABLE);
		end
		mask_d = mask_d & (MASK_WRITABLE | MASK_RESET);
		mask_d[BIT_BUSRST] = 1'b1;
	end

	// Status register: events set, clear register clears, set wins
	always_comb begin
		pend_d = pend_q;
		if (wrAck) begin
			pend_d = pend_d & ~(busReq.wdata & EVENT_BITS);
		end
		if (idleExpired) begin
			pend_d[BIT_SUSPEND] = 1'b1;
		end
		if (busEvt.resumeSeen) begin
			pend_d[BIT_RESUME] = 1'b1;
		end
		if (busEvt.sofToken) begin
			pend_d[BIT_SOF] = 1'b1;
		end
		if (busEvt.busResetDone) begin
			pend_d[BIT_BUSRST] = 1'b1;
		end
		if (busEvt.resumeSeen || busEvt.busResetDone) begin
			pend_d[BIT_WAKEUP] = 1'b1;
		end
		// Endpoint bits mirror their sources; no clear path here
		pend_d[BIT_EP0 +: NUM_EP] = epAny;
	end

	// Suspend state: entered on idle timeout, left on any bus activity
	always_comb begin
		susp_d = susp_q;
		if (busEvt.busActivity) begin
			susp_d = 1'b0;
		end else if (idleExpired) begin
			susp_d = 1'b1;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_comb begin
		rdata_d = '0;
		if (busReq.rd) begin
			case (busReq.addr)
				OFS_ENABLE_VIEW:  rdata_d = mask_q;
				OFS_PENDING_VIEW: rdata_d = pend_q;
				default:          rdata_d = '0;
			endcase
		end
	end

	// Uses next-state values so the output flop tracks status without lag
	assign irq_d = |(pend_d & mask_d);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			mask_q  <= MASK_RESET;
			pend_q  <= PEND_RESET;
			rdata_q <= '0;
			irq_q   <= 1'b0;
			susp_q  <= 1'b0;
		end else begin
			mask_q  <= mask_d;
			pend_q  <= pend_d;
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
			susp_q  <= susp_d;
		end
	end

	assign rdata     = rdata_q;
	assign irq       = irq_q;
	assign suspended = susp_q;

	AST_FIXED_UNMASKABLE_BIT_FIXED: assert property (@(posedge clock) disable iff (!rst_b)
		mask_q[BIT_BUSRST]) else $error("fixed mask bit dropped");
	AST_ENABLE_SETS: assert property (@(posedge clock) disable iff (!rst_b)
		wrSet && busReq.wdata[BIT_SOF] && !wrClr |=> mask_q[BIT_SOF])
		else $error("enable write did not set mask");
	AST_DISABLE_CLRS: assert property (@(posedge clock) disable iff (!rst_b)
		wrClr && busReq.wdata[BIT_SUSPEND] |=> !mask_q[BIT_SUSPEND])
		else $error("disable write did not clear mask");
	AST_MASK_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
		!wrSet && !wrClr |=> mask_q == $past(mask_q))
		else $error("mask changed without write");
	AST_MASK_READ: assert property (@(posedge clock) disable iff (!rst_b)
		busReq.rd && busReq.addr == OFS_ENABLE_VIEW |=> rdata == $past(mask_q))
		else $error("mask read wrong");
	AST_RESET_MASK: assert property (@(posedge clock)
		!rst_b |=> mask_q == MASK_RESET)
		else $error("mask reset value wrong");
	AST_EP_STATUS: assert property (@(posedge clock) disable iff (!rst_b)
		epAny[0] |=> pend_q[BIT_EP0])
		else $error("endpoint status not raised");
	AST_EP_NOCLR: assert property (@(posedge clock) disable iff (!rst_b)
		wrAck && epAny[0] |=> pend_q[BIT_EP0])
		else $error("endpoint status cleared by clear register");
	AST_SOF_SET: assert property (@(posedge clock) disable iff (!rst_b)
		busEvt.sofToken |=> pend_q[BIT_SOF] ##1 (pend_q[BIT_SOF] || $past(wrAck)))
		else $error("frame flag not set");
	AST_WAKE_SET: assert property (@(posedge clock) disable iff (!rst_b)
		busEvt.resumeSeen |=> pend_q[BIT_WAKEUP] && pend_q[BIT_RESUME])
		else $error("resume flags not set");
	AST_CLR_EVT: assert property (@(posedge clock) disable iff (!rst_b)
		wrAck && busReq.wdata[BIT_SOF] && !busEvt.sofToken |=> !pend_q[BIT_SOF])
		else $error("clear did not clear");
	AST_IRQ: assert property (@(posedge clock) disable iff (!rst_b)
		##1 irq == |(pend_q & mask_q))
		else $error("irq does not match status and mask");
	AST_SUSPEND: assert property (@(posedge clock) disable iff (!rst_b)
		idleExpired |=> pend_q[BIT_SUSPEND] && (suspended || $past(busEvt.busActivity)))
		else $error("idle timeout did not suspend");

	AST_EN_SET_EP0: assert property (@(posedge clock) disable iff (!rst_b)
		wrSet && busReq.wdata[BIT_EP0] |=> mask_q[BIT_EP0])
		else $error("enable write did not set endpoint mask");

	AST_EN_SET_SUSP: assert property (@(posedge clock) disable iff (!rst_b)
		wrSet && busReq.wdata[BIT_SUSPEND] |=> mask_q[BIT_SUSPEND])
		else $error("enable write did not set suspend mask");

	AST_EN_SET_RSM: assert property (@(posedge clock) disable iff (!rst_b)
		wrSet && busReq.wdata[BIT_RESUME] |=> mask_q[BIT_RESUME])
		else $error("enable write did not set resume mask");

	AST_EN_SET_WAKE: assert property (@(posedge clock) disable iff (!rst_b)
		wrSet && busReq.wdata[BIT_WAKEUP] |=> mask_q[BIT_WAKEUP])
		else $error("enable write did not set wakeup mask");

	AST_EN_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
		wrSet |=> (mask_q & ~$past(busReq.wdata)) == ($past(mask_q) & ~$past(busReq.wdata)))
		else $error("enable write of zero changed mask");

	AST_DIS_EP0: assert property (@(posedge clock) disable iff (!rst_b)
		wrClr && busReq.wdata[BIT_EP0] |=> !mask_q[BIT_EP0])
		else $error("disable write did not clear endpoint mask");

	AST_DIS_RSM: assert property (@(posedge clock) disable iff (!rst_b)
		wrClr && busReq.wdata[BIT_RESUME] |=> !mask_q[BIT_RESUME])
		else $error("disable write did not clear resume mask");

	AST_DIS_SOF: assert property (@(posedge clock) disable iff (!rst_b)
		wrClr && busReq.wdata[BIT_SOF] |=> !mask_q[BIT_SOF])
		else $error("disable write did not clear frame mask");

	AST_DIS_WAKE: assert property (@(posedge clock) disable iff (!rst_b)
		wrClr && busReq.wdata[BIT_WAKEUP] |=> !mask_q[BIT_WAKEUP])
		else $error("disable write did not clear wakeup mask");

	AST_DIS_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
		wrClr |=> (mask_q | $past(busReq.wdata)) == ($past(mask_q) | $past(busReq.wdata)))
		else $error("disable write of zero changed mask");

	AST_MASK_RSVD: assert property (@(posedge clock) disable iff (!rst_b)
		(mask_q & ~(MASK_WRITABLE | MASK_RESET)) == '0)
		else $error("reserved mask bit set");

	AST_PEND_READ: assert property (@(posedge clock) disable iff (!rst_b)
		busReq.rd && busReq.addr == OFS_PENDING_VIEW |=> rdata == $past(pend_q))
		else $error("status read wrong");

	AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (!rst_b)
		!busReq.rd |=> rdata == '0)
		else $error("read data not zero without read");

	AST_FIXED_UNMASKABLE_BIT_CLR: assert property (@(posedge clock) disable iff (!rst_b)
		wrClr && busReq.wdata[BIT_BUSRST] |=> mask_q[BIT_BUSRST])
		else $error("disable write cleared fixed bit");

	AST_RESET_RSM: assert property (@(posedge clock)
		!rst_b |=> mask_q[BIT_RESUME])
		else $error("resume mask not enabled by reset");

	AST_EP_FOLLOW: assert property (@(posedge clock) disable iff (!rst_b)
		1'b1 |=> pend_q[BIT_EP0 +: NUM_EP] == $past(epAny))
		else $error("endpoint status does not follow flags");

	AST_EP_DROP: assert property (@(posedge clock) disable iff (!rst_b)
		!epAny[1] |=> !pend_q[BIT_EP0 + 1])
		else $error("endpoint status stands without source");

	AST_SUSP_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
		pend_q[BIT_SUSPEND] && !(wrAck && busReq.wdata[BIT_SUSPEND]) |=> pend_q[BIT_SUSPEND])
		else $error("suspend flag lost");

	AST_RSM_SET: assert property (@(posedge clock) disable iff (!rst_b)
		busEvt.resumeSeen |=> pend_q[BIT_RESUME])
		else $error("resume flag not set");

	AST_RSM_CLR: assert property (@(posedge clock) disable iff (!rst_b)
		wrAck && busReq.wdata[BIT_RESUME] && !busEvt.resumeSeen |=> !pend_q[BIT_RESUME])
		else $error("resume flag not cleared");

	AST_BUSRST_SET: assert property (@(posedge clock) disable iff (!rst_b)
		busEvt.busResetDone |=> pend_q[BIT_BUSRST])
		else $error("bus reset flag not set");

	AST_WAKE_RST: assert property (@(posedge clock) disable iff (!rst_b)
		busEvt.busResetDone |=> pend_q[BIT_WAKEUP])
		else $error("wakeup flag not set by bus reset");

	AST_WAKE_ONLY: assert property (@(posedge clock) disable iff (!rst_b)
		!pend_q[BIT_WAKEUP] && !busEvt.resumeSeen && !busEvt.busResetDone |=> !pend_q[BIT_WAKEUP])
		else $error("wakeup flag set without cause");

	AST_SUSP_CLR: assert property (@(posedge clock) disable iff (!rst_b)
		wrAck && busReq.wdata[BIT_SUSPEND] && !idleExpired |=> !pend_q[BIT_SUSPEND])
		else $error("suspend flag not cleared");

	AST_WAKE_CLR: assert property (@(posedge clock) disable iff (!rst_b)
		wrAck && busReq.wdata[BIT_WAKEUP] && !busEvt.resumeSeen && !busEvt.busResetDone
		|=> !pend_q[BIT_WAKEUP])
		else $error("wakeup flag not cleared");

	AST_PEND_RSVD: assert property (@(posedge clock) disable iff (!rst_b)
		pend_q[31:14] == 18'h0 && !pend_q[10] && pend_q[7:6] == 2'h0)
		else $error("reserved status bit set");

	AST_IRQ_RISE: assert property (@(posedge clock) disable iff (!rst_b)
		busEvt.sofToken && mask_q[BIT_SOF] && !wrClr |=> irq)
		else $error("enabled frame event gave no interrupt");

	AST_SUSP_EXIT: assert property (@(posedge clock) disable iff (!rst_b)
		busEvt.busActivity |=> !suspended)
		else $error("bus activity did not leave suspend");

	AST_RESET_OUT: assert property (@(posedge clock)
		!rst_b |=> !irq && rdata == '0)
		else $error("outputs not quiet after reset");
endmodule : udi_irq_regs

// >>> hw/udi_pkg.sv
package udi_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NUM_EP = 6;
	// Byte offsets of the register map
	localparam logic [7:0] OFS_ENABLE_SET   = 8'h10;
	localparam logic [7:0] OFS_ENABLE_CLEAR = 8'h14;
	localparam logic [7:0] OFS_ENABLE_VIEW  = 8'h18;
	localparam logic [7:0] OFS_PENDING_VIEW = 8'h1c;
	localparam logic [7:0] OFS_PENDING_CLR  = 8'h20;
	// Field positions
	localparam int unsigned BIT_EP0     = 0;
	localparam int unsigned BIT_SUSPEND = 8;
	localparam int unsigned BIT_RESUME  = 9;
	localparam int unsigned BIT_SOF     = 11;
	localparam int unsigned BIT_BUSRST  = 12;
	localparam int unsigned BIT_WAKEUP  = 13;
	// Writable mask bits and clearable status bits
	localparam logic [31:0] MASK_WRITABLE = 32'h0000_2b3f;
	localparam logic [31:0] EVENT_BITS    = 32'h0000_3b00;
	localparam logic [31:0] MASK_RESET    = 32'h0000_1200;
	localparam logic [31:0] PEND_RESET    = 32'h0000_0000;
	// Bus idle time before suspend
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned IDLE_TIME_US  = 3000;
	localparam int unsigned IDLE_CYCLES   = IDLE_TIME_US * (CLK_HZ / 1_000_000);

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} udi_bus_req_t;

	typedef struct packed {
		logic busActivity;
		logic resumeSeen;
		logic sofToken;
		logic busResetDone;
	} udi_bus_evt_t;
endpackage : udi_pkg

// >>> hw/udi_idle_timer.sv
`timescale 1ns/1ps
module udi_idle_timer #(
	parameter int unsigned LIMIT = 60000
) (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic activity,
	output logic      expired
);
	localparam int unsigned CW = $clog2(LIMIT + 1);
	initial begin
		if (LIMIT < 2) $error("udi_idle_timer: LIMIT too small");
	end
	logic [CW-1:0] count_q, count_d;
	logic          done_q, done_d;

	// One pulse after LIMIT idle cycles; stays quiet until activity rearms it
	always_comb begin
		count_d = count_q;
		done_d  = 1'b0;
		if (activity) begin
			count_d = '0;
		end else if (count_q < CW'(LIMIT)) begin
			count_d = count_q + CW'(1);
			done_d  = (count_q == CW'(LIMIT - 1));
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			count_q <= '0;
			done_q  <= 1'b0;
		end else begin
			count_q <= count_d;
			done_q  <= done_d;
		end
	end
	assign expired = done_q;
endmodule : udi_idle_timer

// >>> test/udi_host_model.sv
`timescale 1ns/1ps
module udi_host_model
	import udi_pkg::*;
(
	input  wire logic                  clock,
	input  wire udi_pkg::udi_bus_evt_t evtReq,
	output udi_pkg::udi_bus_evt_t      busEvt
);
	// Bus events leave on a clock edge, as the line-state detector would issue them
	always_ff @(posedge clock) begin
		busEvt <= evtReq;
	end
endmodule : udi_host_model

// >>> test/udi_irq_regs_tb_top.sv
`timescale 1ns/1ps
module udi_irq_regs_tb_top;
	import udi_pkg::*;
	logic         clock;
	logic         rst_b;
	udi_bus_req_t busReq;
	logic [31:0]  rdata;
	udi_bus_evt_t evtReq;
	udi_bus_evt_t busEvt;
	logic [5:0]   ep [5];
	logic         suspended;
	logic         irq;
	int           num_errors = 0;
	int           num_checks = 0;

	udi_host_model udi_host_model_inst (.clock(clock), .evtReq(evtReq), .busEvt(busEvt));

	udi_irq_regs #(.IDLE_LIMIT(20)) udi_irq_regs_inst (
		.clock(clock), .rst_b(rst_b), .busReq(busReq), .rdata(rdata), .busEvt(busEvt),
		.setupPacketReceived(ep[0]), .receiveBankAFull(ep[1]), .receiveBankBFull(ep[2]),
		.transmitAcknowledged(ep[3]), .stallAcknowledged(ep[4]),
		.suspended(suspended), .irq(irq)
	);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task summarize;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		busReq <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		busReq.wr <= 1'b0;
	endtask : wr

	// Read data live for one cycle only, so it is sampled just after the taking edge
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		busReq <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clock);
		busReq.rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask : rd

	task pulse(input int b);
		@(posedge clock);
		evtReq[b] <= 1'b1;
		@(posedge clock);
		evtReq[b] <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : pulse

	initial begin
		#(4000 * 50);
		num_errors++;
		summarize();
	end

	initial begin
		rst_b = 1'b0;
		busReq = '0;
		evtReq = 4'h8;
		ep = '{default: '0};
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		rd(OFS_ENABLE_VIEW, MASK_RESET);
		wr(OFS_PENDING_CLR, EVENT_BITS);
		rd(OFS_PENDING_VIEW, 32'h0);
		wr(OFS_ENABLE_SET, 32'hffff_ffff);
		rd(OFS_ENABLE_VIEW, 32'h0000_3b3f);
		wr(OFS_ENABLE_CLEAR, 32'h0000_0a00);
		rd(OFS_ENABLE_VIEW, 32'h0000_313f);
		wr(OFS_ENABLE_CLEAR, 32'hffff_ffff);
		rd(OFS_ENABLE_VIEW, 32'h0000_1000);
		pulse(1);
		rd(OFS_PENDING_VIEW, 32'h0000_0800);
		chk("irq", 1'b0, irq);
		wr(OFS_ENABLE_SET, 32'h0000_0800);
		repeat (2) @(posedge clock);
		#1 chk("irq", 1'b1, irq);
		wr(OFS_PENDING_CLR, 32'h0000_0800);
		rd(OFS_PENDING_VIEW, 32'h0);
		pulse(2);
		rd(OFS_PENDING_VIEW, 32'h0000_2200);
		wr(OFS_PENDING_CLR, 32'h0000_2200);
		pulse(0);
		rd(OFS_PENDING_VIEW, 32'h0000_3000);
		chk("irq", 1'b1, irq);
		wr(OFS_PENDING_CLR, 32'h0000_3000);
		rd(OFS_PENDING_VIEW, 32'h0);
		// Flag kind k raised on endpoint k, so every flag input is reached
		for (int k = 0; k < 5; k++) begin
			@(posedge clock);
			ep[k][k] <= 1'b1;
			rd(OFS_PENDING_VIEW, 32'h1 << k);
			wr(OFS_PENDING_CLR, 32'hffff_ffff);
			rd(OFS_PENDING_VIEW, 32'h1 << k);
			@(posedge clock);
			ep[k][k] <= 1'b0;
			rd(OFS_PENDING_VIEW, 32'h0);
		end
		@(posedge clock);
		evtReq.busActivity <= 1'b0;
		repeat (30) @(posedge clock);
		#1 chk("suspended", 1'b1, suspended);
		rd(OFS_PENDING_VIEW, 32'h0000_0100);
		@(posedge clock);
		evtReq.busActivity <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk("suspended", 1'b0, suspended);
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rd(OFS_ENABLE_VIEW, MASK_RESET);
		rd(OFS_PENDING_VIEW, PEND_RESET);
		chk("irq", 1'b0, irq);
		summarize();
	end
endmodule : udi_irq_regs_tb_top
